// [bench/t1_framer_model.sv]
// behavioural framer model: line rails, framing strobe, stream clock, streams
`timescale 1ns/10ps

module t1_framer_model #(
    parameter logic [7:0] FEATURE = 8'h00,
    parameter logic [7:0] BOM     = 8'h00,
    parameter logic [7:0] LOOP    = 8'h00
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [7:0] gap_in,
    output logic            lclk_out,
    output logic            rail_a_n_out,
    output logic            rail_b_n_out,
    output logic            strobe_n_out,
    output logic            bclk_out,
    output logic            fp_n_out,
    output logic            st0_out,
    output logic            st1_out
);
    // ------------------------------------------------------------
    // free-running line and stream clocks, both held low while reset is asserted
    // ------------------------------------------------------------
    int         lph;
    int         bph;
    logic [7:0] lbit;
    logic [7:0] sbit;
    logic [7:0] b0;
    logic [7:0] b1;

    // line counter starts near the gap so the first strobe comes early
    always @(negedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lph = 0;
            lbit = 8'ha4;
            lclk_out <= 1'b0;
            strobe_n_out <= 1'b1;
            rail_a_n_out <= 1'b1;
            rail_b_n_out <= 1'b1;
        end else begin
            lph = (lph == 161) ? 0 : lph + 1;
            if (lph == 81) begin
                lclk_out <= 1'b1;
            end else if (lph == 0) begin
                lclk_out <= 1'b0;
                lbit = (lbit + 8'h01 == gap_in) ? 8'h00 : lbit + 8'h01;
                strobe_n_out <= (lbit != 8'h00);
                rail_a_n_out <= lbit[0];
                rail_b_n_out <= lbit[1];
            end
        end
    end

    always @(negedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bph = 0;
            sbit = 8'hfa;
            bclk_out <= 1'b0;
            fp_n_out <= 1'b1;
            st0_out <= 1'b1;
            st1_out <= 1'b1;
        end else begin
            bph = (bph == 121) ? 0 : bph + 1;
            if (bph == 61) begin
                bclk_out <= 1'b1;
            end else if (bph == 0) begin
                bclk_out <= 1'b0;
                sbit = sbit + 8'h01;
                fp_n_out <= (sbit != 8'hff);
                b0 = 8'ha5 ^ {3'h0, sbit[7:3]};
                case (sbit[7:3])
                    5'h0b: b1 = FEATURE;
                    5'h07: b1 = BOM;
                    5'h0f: b1 = LOOP;
                    default: b1 = 8'h00;
                endcase
                st0_out <= b0[3'h7 - sbit[2:0]];
                st1_out <= b1[3'h7 - sbit[2:0]];
            end
        end
    end
endmodule // t1_framer_model

// [bench/t1_monitor_stream_front_end_tb.sv]
// self-checking bench for the t1 monitor front end
`timescale 1ns/10ps

`define CHECK(got, exp, msg) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("mismatch at %0t: %s", $time, msg); \
    end \
end

module t1_monitor_stream_front_end_tb;
    localparam logic [7:0] FEATURE = 8'h2c;
    localparam logic [7:0] BOM     = 8'h9b;
    localparam logic [7:0] LOOP    = 8'h3e;

    logic       clk;
    logic       rst_n;
    logic [7:0] gap;
    logic       lclk, rail_a_n, rail_b_n, strobe_n, bclk, fp_n, st0, st1;
    logic       strobe_o, stream_o, fbit, ferr;
    logic [1:0] rx_bits;
    logic [7:0] feat, bom, loop;
    logic [1:0] last_rails;
    int         mismatches;
    int         samples_checked;

    t1_monitor_stream_front_end dut_u (
        .clk_in                  (clk),
        .rst_n_in                (rst_n),
        .line_recovered_clock_in (lclk),
        .rx_rail_a_n_in          (rail_a_n),
        .rx_rail_b_n_in          (rail_b_n),
        .framing_strobe_n_in     (strobe_n),
        .stream_bit_clock_in     (bclk),
        .frame_pulse_n_in        (fp_n),
        .ctrl_stream_in_zero_in  (st0),
        .ctrl_stream_in_one_in   (st1),
        .framing_strobe_out      (strobe_o),
        .ctrl_stream_out         (stream_o),
        .rx_bits_out             (rx_bits),
        .rx_framing_bit_out      (fbit),
        .framing_error_out       (ferr),
        .feature_ctrl_out        (feat),
        .tx_bom_out              (bom),
        .loopback_ctrl_out       (loop)
    );

    t1_framer_model #(.FEATURE(FEATURE), .BOM(BOM), .LOOP(LOOP)) framer_u (
        .clk_in       (clk),
        .rst_n_in     (rst_n),
        .gap_in       (gap),
        .lclk_out     (lclk),
        .rail_a_n_out (rail_a_n),
        .rail_b_n_out (rail_b_n),
        .strobe_n_out (strobe_n),
        .bclk_out     (bclk),
        .fp_n_out     (fp_n),
        .st0_out      (st0),
        .st1_out      (st1)
    );

    always #2 clk = ~clk;

    // rail marks at the last line clock rise, the bit just before a strobe
    always @(posedge lclk) last_rails <= {~rail_b_n, ~rail_a_n};

    task automatic end_of_test();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return lclk;
            1: return strobe_n;
            2: return bclk;
            default: return fp_n;
        endcase
    endfunction

    // bounded wait on a model pin, a full strobe gap is about 31k cycles
    task automatic wait_for(input int s, input logic v);
        int n;
        n = 0;
        while (pick(s) !== v) begin
            @(negedge clk);
            n++;
            if (n > 40000) begin
                mismatches++;
                end_of_test();
            end
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic check_reset();
        `CHECK(strobe_o, 1'b1, "strobe out in reset")
        `CHECK(stream_o, 1'b1, "stream out in reset")
        `CHECK({rx_bits, fbit, ferr}, 4'h0, "line outs in reset")
        `CHECK({feat, bom, loop}, 24'h000000, "ctrl outs in reset")
    endtask

    task automatic check_rails();
        repeat (4) begin
            wait_for(0, 1'b0);
            wait_for(0, 1'b1);
            repeat (10) @(negedge clk);
            `CHECK(rx_bits, {~rail_b_n, ~rail_a_n}, "rail bits")
        end
    endtask

    task automatic check_strobe(input logic err, input logic echo, input logic [7:0] nxt);
        logic seen_err;
        logic seen_low;
        logic exp_fbit;
        seen_err = 1'b0;
        seen_low = 1'b0;
        wait_for(1, 1'b1);
        wait_for(1, 1'b0);
        exp_fbit = |last_rails;
        gap = nxt;
        repeat (12) begin
            @(negedge clk);
            seen_err = seen_err | ferr;
            seen_low = seen_low | ~strobe_o;
        end
        `CHECK(seen_err, err, "framing error flag")
        `CHECK(seen_low, echo, "strobe echo")
        `CHECK(fbit, exp_fbit, "framing bit")
    endtask

    task automatic check_stream();
        int ch;
        wait_for(3, 1'b0);
        wait_for(2, 1'b1);
        wait_for(2, 1'b0);
        for (int i = 0; i < 256; i++) begin
            ch = i / 8;
            wait_for(2, 1'b1);
            repeat (10) @(negedge clk);
            // channels 1 and 2 pass before the first strobe, so both still carry zero
            if (ch == int'(t1_mon_pkg::CH_INS_STATUS) || ch == int'(t1_mon_pkg::CH_INS_ERRCNT))
                `CHECK(stream_o, 1'b0, "inserted bit")
            else
                `CHECK(stream_o, st0, "pass-through bit")
            wait_for(2, 1'b0);
        end
        `CHECK(feat, FEATURE, "feature byte")
        `CHECK(bom, BOM, "message byte")
        `CHECK(loop, LOOP, "loopback byte")
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        // first spacing ends on a space, so the first framing bit reads zero
        gap = 8'hc4;
        mismatches = 0;
        samples_checked = 0;
        repeat (8) @(negedge clk);
        check_reset();
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        fork
            begin
                check_rails();
                // first strobe only locks; 194 spacing must then flag once
                check_strobe(1'b0, 1'b0, 8'hc2);
                check_strobe(1'b1, 1'b1, 8'hc1);
                check_strobe(1'b0, 1'b1, 8'hc1);
            end
            check_stream();
        join
        end_of_test();
    end
endmodule // t1_monitor_stream_front_end_tb

// [hdl/t1_mon_pkg.sv]
// constants package and pin synchroniser for the t1 monitor front end
`timescale 1ns/10ps

package t1_mon_pkg;
    // ------------------------------------------------------------
    // clocks and frame geometry
    // ------------------------------------------------------------
    localparam int         SYS_CLK_KHZ     = 250000;
    localparam int         LINE_CLK_KHZ    = 1544;
    localparam int         STREAM_CLK_KHZ  = 2048;
    localparam logic [7:0] LINE_FRAME_BITS = 8'hc1;
    localparam logic [7:0] LINE_CNT_MAX    = 8'hff;
    localparam logic [2:0] LAST_BIT_POS    = 3'h7;
    localparam logic [7:0] STREAM_CNT_STEP = 8'h01;
    // ------------------------------------------------------------
    // stream channel map
    // ------------------------------------------------------------
    localparam logic [4:0] CH_TX_BOM       = 5'h07;
    localparam logic [4:0] CH_FEATURE      = 5'h0b;
    localparam logic [4:0] CH_LOOPBACK     = 5'h0f;
    localparam logic [4:0] CH_INS_STATUS   = 5'h01;
    localparam logic [4:0] CH_INS_ERRCNT   = 5'h02;
    // ------------------------------------------------------------
    // control fields and reset values
    // ------------------------------------------------------------
    localparam int         STROBE_EN_BIT   = 2;
    localparam logic [7:0] FEATURE_RST     = 8'h00;
    localparam logic [7:0] BOM_RST         = 8'h00;
    localparam logic [7:0] LOOPBACK_RST    = 8'h00;
    localparam logic [7:0] ERRCNT_RST      = 8'h00;
endpackage

// three-stage pin synchroniser; level moves once stages two and three agree
module pin_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic pin_in,
    output logic      level_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } sync_t;

    sync_t state_reg;
    sync_t state_next;

    always_comb begin
        state_next     = state_reg;
        state_next.s1  = pin_in;
        state_next.s2  = state_reg.s1;
        state_next.s3  = state_reg.s2;
        if (state_reg.s2 == state_reg.s3) begin
            state_next.lvl = state_reg.s3;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, lvl: RST_VAL};
        end else begin
            state_reg <= state_next;
        end
    end

    assign level_out = state_reg.lvl;
endmodule // pin_sync

// [hdl/t1_monitor_stream_front_end.sv]
// t1 monitor front end: rail sampling, framing check, strobe echo, stream pass-through
`timescale 1ns/10ps

// Overview of operation
// RULE1: rails are sampled on each rising edge of the recovered line clock.
// RULE2: both rails are active low; a low rail reads as a one.
// RULE3: falling framing strobe marks framing bit; wrong bit spacing flags an error.
// RULE4: strobe output follows strobe input when feature bit 2 set, else high.
// RULE5: stream zero passes to stream output, own status bytes replace two channels.
// RULE6: stream one channel 11 is feature control, 7 transmit message, 15 loopback.
// RULE7: framer supplies 8 kHz frame pulse; channel timing aligns to it.
// RULE8: stream bits move on the 2.048 MHz stream bit clock.
// RULE9: low reset suspends everything; operation needs reset held high.
// RULE10: frame is 32 channels of 8 bits, msb first, channel 0 at pulse.
module t1_monitor_stream_front_end (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       line_recovered_clock_in,
    input  wire logic       rx_rail_a_n_in,
    input  wire logic       rx_rail_b_n_in,
    input  wire logic       framing_strobe_n_in,
    input  wire logic       stream_bit_clock_in,
    input  wire logic       frame_pulse_n_in,
    input  wire logic       ctrl_stream_in_zero_in,
    input  wire logic       ctrl_stream_in_one_in,
    output logic            framing_strobe_out,
    output logic            ctrl_stream_out,
    output logic [1:0]      rx_bits_out,
    output logic            rx_framing_bit_out,
    output logic            framing_error_out,
    output logic [7:0]      feature_ctrl_out,
    output logic [7:0]      tx_bom_out,
    output logic [7:0]      loopback_ctrl_out
);
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_HUNT = 2'b01,
        ST_RUN  = 2'b10
    } stream_state_t;

    typedef struct packed {
        logic          lclk_d;
        logic          sclk_d;
        logic          strobe_d;
        logic [7:0]    line_cnt;
        logic          locked;
        logic [1:0]    rx_bits;
        logic          fbit;
        logic          ferr;
        logic          ferr_sticky;
        logic [7:0]    ferr_cnt;
        stream_state_t fsm;
        logic          fp_seen;
        logic [7:0]    bit_cnt;
        logic [7:0]    sh1;
        logic [7:0]    feature;
        logic [7:0]    bom;
        logic [7:0]    loopback;
        logic          strobe_out;
        logic          cso;
    } state_t;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic lclk_lvl;
    logic rail_a_lvl;
    logic rail_b_lvl;
    logic strobe_lvl;
    logic sclk_lvl;
    logic fp_lvl;
    logic s0_lvl;
    logic s1_lvl;

    pin_sync #(.RST_VAL(1'b0)) u_sync_lclk (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .pin_in(line_recovered_clock_in), .level_out(lclk_lvl));
    pin_sync #(.RST_VAL(1'b1)) u_sync_ra (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .pin_in(rx_rail_a_n_in), .level_out(rail_a_lvl));
    pin_sync #(.RST_VAL(1'b1)) u_sync_rb (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .pin_in(rx_rail_b_n_in), .level_out(rail_b_lvl));
    pin_sync #(.RST_VAL(1'b1)) u_sync_strb (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .pin_in(framing_strobe_n_in), .level_out(strobe_lvl));
    pin_sync #(.RST_VAL(1'b0)) u_sync_sclk (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .pin_in(stream_bit_clock_in), .level_out(sclk_lvl));
    pin_sync #(.RST_VAL(1'b1)) u_sync_fp (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .pin_in(frame_pulse_n_in), .level_out(fp_lvl));
    pin_sync #(.RST_VAL(1'b1)) u_sync_s0 (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .pin_in(ctrl_stream_in_zero_in), .level_out(s0_lvl));
    pin_sync #(.RST_VAL(1'b1)) u_sync_s1 (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .pin_in(ctrl_stream_in_one_in), .level_out(s1_lvl));

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    state_t     state_reg;
    state_t     state_next;
    logic       lclk_rise;
    logic       strobe_fall;
    logic       sclk_rise;
    logic       sclk_fall;
    logic [4:0] chan;
    logic [2:0] bitpos;
    logic [7:0] byte_in;
    logic [7:0] ins_byte;
    logic [1:0] rails_lvl;
    logic       ins_chan;

    assign lclk_rise   = lclk_lvl & ~state_reg.lclk_d;
    assign strobe_fall = ~strobe_lvl & state_reg.strobe_d;
    assign sclk_rise   = sclk_lvl & ~state_reg.sclk_d;
    assign sclk_fall   = ~sclk_lvl & state_reg.sclk_d;
    assign chan        = state_reg.bit_cnt[7:3];
    assign bitpos      = state_reg.bit_cnt[2:0];
    assign byte_in     = {state_reg.sh1[6:0], s1_lvl};
    assign rails_lvl   = {rail_b_lvl, rail_a_lvl};
    assign ins_chan    = (chan == t1_mon_pkg::CH_INS_STATUS) ||
                         (chan == t1_mon_pkg::CH_INS_ERRCNT);
    assign ins_byte    = (chan == t1_mon_pkg::CH_INS_STATUS) ?
                         {4'h0, state_reg.ferr_sticky, state_reg.locked, state_reg.fbit, 1'b0} :
                         state_reg.ferr_cnt;

    always_comb begin
        state_next          = state_reg;
        state_next.lclk_d   = lclk_lvl;
        state_next.sclk_d   = sclk_lvl;
        state_next.strobe_d = strobe_lvl;
        state_next.ferr     = 1'b0;
        // line side
        if (lclk_rise) begin
            state_next.rx_bits = ~rails_lvl;                               // see RULE1 see RULE2
            if (state_reg.line_cnt != t1_mon_pkg::LINE_CNT_MAX) begin
                state_next.line_cnt = state_reg.line_cnt + 8'h01;
            end
        end
        if (strobe_fall) begin
            // framing bit is whatever the rails last carried
            state_next.fbit     = |state_reg.rx_bits;                      // see RULE3
            state_next.locked   = 1'b1;
            state_next.line_cnt = lclk_rise ? 8'h01 : 8'h00;
            if (state_reg.locked && state_reg.line_cnt != t1_mon_pkg::LINE_FRAME_BITS) begin
                state_next.ferr = 1'b1;                                    // see RULE3
                if (state_reg.ferr_cnt != t1_mon_pkg::LINE_CNT_MAX) begin
                    state_next.ferr_cnt = state_reg.ferr_cnt + 8'h01;
                end
            end
        end
        // strobe echo
        state_next.strobe_out = state_reg.feature[t1_mon_pkg::STROBE_EN_BIT] ?
                                strobe_lvl : 1'b1;                         // see RULE4
        // stream side
        if (sclk_rise && !fp_lvl) begin
            state_next.fp_seen = 1'b1;                                     // see RULE7
        end
        case (state_reg.fsm)
            ST_HUNT: begin
                // no alignment yet: plain pass-through, nothing decoded
                state_next.cso = s0_lvl;                                   // see RULE5
                if (sclk_fall && state_reg.fp_seen) begin
                    state_next.fsm     = ST_RUN;
                    state_next.fp_seen = 1'b0;
                    state_next.bit_cnt = 8'h00;                            // see RULE7
                end
            end
            ST_RUN: begin
                if (sclk_fall) begin                                       // see RULE8
                    if (state_reg.fp_seen) begin
                        state_next.fp_seen = 1'b0;
                        state_next.bit_cnt = 8'h00;                        // see RULE10
                    end else begin
                        state_next.bit_cnt = state_reg.bit_cnt + t1_mon_pkg::STREAM_CNT_STEP;
                    end
                end
                if (sclk_rise) begin                                       // see RULE8
                    state_next.sh1 = byte_in;                              // see RULE10
                    state_next.cso = ins_chan ?
                        ins_byte[t1_mon_pkg::LAST_BIT_POS - bitpos] : s0_lvl; // see RULE5
                    if (bitpos == t1_mon_pkg::LAST_BIT_POS) begin
                        case (chan)
                            t1_mon_pkg::CH_FEATURE:  state_next.feature  = byte_in; // see RULE6
                            t1_mon_pkg::CH_TX_BOM:   state_next.bom      = byte_in; // see RULE6
                            t1_mon_pkg::CH_LOOPBACK: state_next.loopback = byte_in; // see RULE6
                            default: begin
                            end
                        endcase
                        // sticky error is cleared once reported
                        if (chan == t1_mon_pkg::CH_INS_STATUS) begin
                            state_next.ferr_sticky = 1'b0;
                        end
                    end
                end
            end
            default: begin
                state_next.fsm = ST_HUNT;
            end
        endcase
        // a new error wins over the report-clear
        if (state_next.ferr) begin
            state_next.ferr_sticky = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin                                               // see RULE9
            state_reg            <= '0;
            state_reg.strobe_d   <= 1'b1;
            state_reg.fsm        <= ST_HUNT;
            state_reg.feature    <= t1_mon_pkg::FEATURE_RST;
            state_reg.bom        <= t1_mon_pkg::BOM_RST;
            state_reg.loopback   <= t1_mon_pkg::LOOPBACK_RST;
            state_reg.ferr_cnt   <= t1_mon_pkg::ERRCNT_RST;
            state_reg.strobe_out <= 1'b1;
            state_reg.cso        <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign framing_strobe_out = state_reg.strobe_out;
    assign ctrl_stream_out    = state_reg.cso;
    assign rx_bits_out        = state_reg.rx_bits;
    assign rx_framing_bit_out = state_reg.fbit;
    assign framing_error_out  = state_reg.ferr;
    assign feature_ctrl_out   = state_reg.feature;
    assign tx_bom_out         = state_reg.bom;
    assign loopback_ctrl_out  = state_reg.loopback;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_strobe_follow;
        feature_ctrl_out[t1_mon_pkg::STROBE_EN_BIT] |=> framing_strobe_out == $past(strobe_lvl);
    endproperty
    a_strobe_follow: assert property (p_strobe_follow) // see RULE4
        else $error("strobe output not following input");

    property p_strobe_high;
        !feature_ctrl_out[t1_mon_pkg::STROBE_EN_BIT] |=> framing_strobe_out;
    endproperty
    a_strobe_high: assert property (p_strobe_high) // see RULE4
        else $error("strobe output not held high");

    property p_rail_sample;
        lclk_rise |=> rx_bits_out == ~$past(rails_lvl);
    endproperty
    a_rail_sample: assert property (p_rail_sample) // see RULE1
        else $error("rails not sampled inverted on line clock");

    property p_ferr_bad;
        strobe_fall && state_reg.locked && state_reg.line_cnt != t1_mon_pkg::LINE_FRAME_BITS
            |=> framing_error_out ##1 !framing_error_out;
    endproperty
    a_ferr_bad: assert property (p_ferr_bad) // see RULE3
        else $error("framing error not flagged for one cycle");

    property p_ferr_ok;
        strobe_fall && state_reg.line_cnt == t1_mon_pkg::LINE_FRAME_BITS |=> !framing_error_out;
    endproperty
    a_ferr_ok: assert property (p_ferr_ok) // see RULE3
        else $error("framing error flagged on good spacing");

    property p_align;
        sclk_fall && state_reg.fp_seen |=> state_reg.bit_cnt == 8'h00 && state_reg.fsm == ST_RUN;
    endproperty
    a_align: assert property (p_align) // see RULE7
        else $error("channel timing not aligned to frame pulse");

    property p_bit_step;
        sclk_fall && !state_reg.fp_seen && state_reg.fsm == ST_RUN
            |=> state_reg.bit_cnt == $past(state_reg.bit_cnt) + 8'h01;
    endproperty
    a_bit_step: assert property (p_bit_step) // see RULE10
        else $error("bit counter did not advance");

    property p_feature_load;
        sclk_rise && state_reg.fsm == ST_RUN && chan == t1_mon_pkg::CH_FEATURE &&
            bitpos == t1_mon_pkg::LAST_BIT_POS |=> feature_ctrl_out == $past(byte_in);
    endproperty
    a_feature_load: assert property (p_feature_load) // see RULE6
        else $error("feature byte not captured");

    property p_pass;
        sclk_rise && state_reg.fsm == ST_RUN && !ins_chan |=> ctrl_stream_out == $past(s0_lvl);
    endproperty
    a_pass: assert property (p_pass) // see RULE5
        else $error("stream zero bit not forwarded");
endmodule // t1_monitor_stream_front_end
